// *** hdl/imps_pkg.sv ***
// package: register map, source layout, vectors and priorities of the interrupt logic
package imps_pkg;
    localparam int          NSRC          = 16;
    localparam int          NSVC          = 15;
    localparam logic [7:0]  OFF_SEL       = 8'h04;
    localparam logic [7:0]  OFF_EOT       = 8'h06;
    localparam logic [7:0]  OFF_PEND_LO   = 8'h09;
    localparam logic [7:0]  OFF_PEND_HI   = 8'h12;
    localparam logic [7:0]  OFF_MASK_HI   = 8'h13;
    localparam logic [7:0]  OFF_MASK_LO   = 8'h08;
    localparam logic [15:0] RST_SEL       = 16'h0000;
    localparam logic [15:0] RST_EOT       = 16'h0000;
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [15:0] SEL_WMASK     = 16'h5FFF;
    localparam logic [7:0]  MASK_HI_WMASK = 8'h5F;
    localparam int          NMI_BIT       = 15;
    localparam int          RSV_BIT       = 13;
    localparam logic [15:0] STD_VEC_BASE  = 16'h2000;
    localparam logic [15:0] STD_VEC_HI_BASE = 16'h2030;
    localparam logic [15:0] MCT_VEC_BASE  = 16'h2040;
    localparam logic [4:0]  PRI_NMI       = 5'h1E;
    localparam logic [4:0]  PRI_MCT_BASE  = 5'h0F;
    localparam logic [3:0]  IDX_NMI       = 4'hF;

    typedef enum logic [1:0] {
        IMPS_OP_NONE,
        IMPS_OP_PUSH,
        IMPS_OP_POP
    } imps_op_t;
endpackage : imps_pkg

// *** hdl/imps_if.sv ***
// interface: source requests, core vectoring and register access between core side and controller
interface imps_if;
    import imps_pkg::*;
    logic [15:0] src_req;
    logic        global_enable_op;
    logic        global_disable_op;
    logic        push_flags_op;
    logic        push_all_op;
    logic        pop_flags_op;
    logic        pop_all_op;
    logic [15:0] stack_wdata;
    logic        reg_wr;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        vec_ack;
    logic        count_zero;
    logic [3:0]  count_zero_src;
    logic        irq_valid;
    logic        irq_is_mct;
    logic [3:0]  irq_src;
    logic [15:0] irq_vector;
    logic [4:0]  irq_priority;
    logic [15:0] psw_low_save;

    modport ctrl (
        input  src_req, global_enable_op, global_disable_op, push_flags_op, push_all_op,
               pop_flags_op, pop_all_op, stack_wdata, reg_wr, reg_addr, reg_wdata,
               vec_ack, count_zero, count_zero_src,
        output reg_rdata, irq_valid, irq_is_mct, irq_src, irq_vector, irq_priority, psw_low_save
    );
    modport core (
        output src_req, global_enable_op, global_disable_op, push_flags_op, push_all_op,
               pop_flags_op, pop_all_op, stack_wdata, reg_wr, reg_addr, reg_wdata,
               vec_ack, count_zero, count_zero_src,
        input  reg_rdata, irq_valid, irq_is_mct, irq_src, irq_vector, irq_priority, psw_low_save
    );
endinterface : imps_if

// *** hdl/imps_ctrl.sv ***
// controller end: mask, pending, service-select and end-of-transfer state with priority pick
//
// Behaviour
// - mask bit zero blocks its source
// - global enable gates all maskable interrupts
// - push saves and clears low mask; pop restores
// - no interrupt except nmi right after a push
// - high mask byte RW; push/pop all save it
// - detected request sets pending bit
// - vector taken clears pending bit
// - software set pending acts as request
// - nonmaskable always enabled; write zero there
// - low byte: bus rx, tx, converter, ch0-3, shared
// - high byte: nmi, pin, rsvd, rx, tx, sync, status
// - shared line raised by decoded capture sources
// - select bit routes to microcode transfer
// - select/eot layout bit 14 down, 13 reserved
// - transfer vectors 205CH down to 2040H
// - count zero clears select, sets end-of-transfer
// - end-of-transfer cleared when standard vector called
// - routine re-sets select bit afterwards
// - avoid transfer service for shared source
// - priorities 30 to 0, transfers above standard
// - standard vectors 203EH down to 2000H
//
// The APB register port was decided locally.
module imps_ctrl (
    input  wire logic pclk,
    input  wire logic presetn,
    imps_if.ctrl      bus
);
    import imps_pkg::*;

    logic [7:0]  mask_lo_r;
    logic [7:0]  mask_hi_r;
    logic [15:0] pend_r;
    logic [15:0] sel_r;
    logic [15:0] eot_r;
    logic        gie_r;
    logic        push_block_r;
    logic [15:0] rdata_r;
    logic        irq_valid_r;
    logic        irq_is_mct_r;
    logic [3:0]  irq_src_r;
    logic [15:0] irq_vector_r;
    logic [4:0]  irq_priority_r;
    logic [15:0] psw_low_save_r;

    logic [15:0] enabled;
    logic [15:0] std_cand;
    logic [15:0] mct_cand;
    logic        pick_valid_nxt;
    logic        pick_mct_nxt;
    logic [3:0]  pick_src_nxt;
    logic [15:0] vec_clr;
    logic [15:0] eot_clr;
    logic [15:0] cz_set;
    logic        push_any;
    logic        pop_any;
    logic [15:0] std_vec;

    assign push_any = bus.push_flags_op | bus.push_all_op;
    assign pop_any  = bus.pop_flags_op | bus.pop_all_op;

    // per-source enable: nmi ignores its mask bit and the global enable
    always_comb begin
        enabled          = {mask_hi_r, mask_lo_r} & {16{gie_r}};
        enabled[NMI_BIT] = 1'b1;
        enabled[RSV_BIT] = 1'b0;
    end

    assign mct_cand = pend_r & enabled & sel_r & ~(16'h1 << NMI_BIT);
    // an end-of-transfer request is served through the standard vector
    assign std_cand = (pend_r | eot_r) & enabled & ~sel_r;
    // standard vectors: sources 15..8 in the upper group, 7..0 from the base
    assign std_vec  = pick_src_nxt[3] ? STD_VEC_HI_BASE + {12'h000, pick_src_nxt[2:0], 1'b0}
                                      : STD_VEC_BASE + {12'h000, pick_src_nxt[2:0], 1'b0};

    // nmi first, then transfers highest index first, then standard highest first
    always_comb begin
        pick_valid_nxt = 1'b0;
        pick_mct_nxt   = 1'b0;
        pick_src_nxt   = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (std_cand[i] && !(pick_valid_nxt && pick_mct_nxt)) begin
                pick_valid_nxt = 1'b1;
                pick_src_nxt   = 4'(i);
            end
        end
        for (int i = 0; i < NSVC; i++) begin
            if (mct_cand[i]) begin
                pick_valid_nxt = 1'b1;
                pick_mct_nxt   = 1'b1;
                pick_src_nxt   = 4'(i);
            end
        end
        if (pend_r[NMI_BIT]) begin
            pick_valid_nxt = 1'b1;
            pick_mct_nxt   = 1'b0;
            pick_src_nxt   = IDX_NMI;
        end
        if (push_block_r && !pend_r[NMI_BIT]) begin
            pick_valid_nxt = 1'b0;
        end
    end

    // clears caused by the core taking the presented vector, and the count-zero set
    always_comb begin
        vec_clr = '0;
        eot_clr = '0;
        cz_set  = '0;
        if (bus.vec_ack && irq_valid_r) begin
            vec_clr[irq_src_r] = 1'b1;
            if (!irq_is_mct_r) begin
                eot_clr[irq_src_r] = 1'b1;
            end
        end
        if (bus.count_zero) begin
            cz_set[bus.count_zero_src] = 1'b1;
        end
    end

    // pending: hardware and software sets win over the vector clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= {RST_BYTE, RST_BYTE};
        end else begin
            logic [15:0] sw;
            sw = '0;
            if (bus.reg_wr && bus.reg_addr == OFF_PEND_LO) begin
                sw[7:0] = bus.reg_wdata[7:0];
            end
            if (bus.reg_wr && bus.reg_addr == OFF_PEND_HI) begin
                sw[15:8] = bus.reg_wdata[7:0];
            end
            if (bus.reg_wr && bus.reg_addr == OFF_PEND_LO) begin
                pend_r[7:0] <= bus.reg_wdata[7:0] | bus.src_req[7:0];
                pend_r[15:8] <= (pend_r[15:8] & ~vec_clr[15:8]) | bus.src_req[15:8] | sw[15:8];
            end else if (bus.reg_wr && bus.reg_addr == OFF_PEND_HI) begin
                pend_r[15:8] <= bus.reg_wdata[7:0] | bus.src_req[15:8];
                pend_r[7:0]  <= (pend_r[7:0] & ~vec_clr[7:0]) | bus.src_req[7:0];
            end else begin
                pend_r <= (pend_r & ~vec_clr) | bus.src_req;
            end
        end
    end

    // low mask: part of the status word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_lo_r <= RST_BYTE;
        end else if (pop_any) begin
            mask_lo_r <= bus.stack_wdata[7:0];
        end else if (push_any) begin
            mask_lo_r <= RST_BYTE;
        end else if (bus.reg_wr && bus.reg_addr == OFF_MASK_LO) begin
            mask_lo_r <= bus.reg_wdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_hi_r <= RST_BYTE;
        end else if (bus.pop_all_op) begin
            mask_hi_r <= bus.stack_wdata[15:8];
        end else if (bus.reg_wr && bus.reg_addr == OFF_MASK_HI) begin
            mask_hi_r <= bus.reg_wdata[7:0];
        end
    end

    // image pushed by the core: {high mask, low mask}
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psw_low_save_r <= '0;
        end else begin
            psw_low_save_r <= {mask_hi_r, mask_lo_r};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_r        <= 1'b0;
            push_block_r <= 1'b0;
        end else begin
            push_block_r <= push_any;
            if (bus.global_enable_op) begin
                gie_r <= 1'b1;
            end else if (bus.global_disable_op) begin
                gie_r <= 1'b0;
            end
        end
    end

    // select: count zero clears, software write otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r <= RST_SEL;
        end else if (bus.reg_wr && bus.reg_addr == OFF_SEL) begin
            sel_r <= bus.reg_wdata & SEL_WMASK & ~cz_set;
        end else begin
            sel_r <= sel_r & ~cz_set;
        end
    end

    // end-of-transfer: set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eot_r <= RST_EOT;
        end else begin
            eot_r <= ((eot_r & ~eot_clr) | cz_set) & SEL_WMASK;
        end
    end

    // presented request and read data, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_valid_r    <= 1'b0;
            irq_is_mct_r   <= 1'b0;
            irq_src_r      <= '0;
            irq_vector_r   <= STD_VEC_BASE;
            irq_priority_r <= '0;
        end else begin
            irq_valid_r  <= pick_valid_nxt & ~(bus.vec_ack & irq_valid_r);
            irq_is_mct_r <= pick_mct_nxt;
            irq_src_r    <= pick_src_nxt;
            if (pick_mct_nxt) begin
                irq_vector_r   <= MCT_VEC_BASE + {11'h0, pick_src_nxt, 1'b0};
                irq_priority_r <= PRI_MCT_BASE + {1'b0, pick_src_nxt};
            end else if (pick_src_nxt == IDX_NMI) begin
                irq_vector_r   <= std_vec;
                irq_priority_r <= PRI_NMI;
            end else begin
                irq_vector_r   <= std_vec;
                irq_priority_r <= {1'b0, pick_src_nxt};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= '0;
        end else begin
            case (bus.reg_addr)
                OFF_SEL:     rdata_r <= sel_r;
                OFF_EOT:     rdata_r <= eot_r;
                OFF_PEND_LO: rdata_r <= {8'h00, pend_r[7:0]};
                OFF_PEND_HI: rdata_r <= {8'h00, pend_r[15:8]};
                OFF_MASK_HI: rdata_r <= {8'h00, mask_hi_r};
                OFF_MASK_LO: rdata_r <= {8'h00, mask_lo_r};
                default:     rdata_r <= '0;
            endcase
        end
    end

    assign bus.reg_rdata    = rdata_r;
    assign bus.irq_valid    = irq_valid_r;
    assign bus.irq_is_mct   = irq_is_mct_r;
    assign bus.irq_src      = irq_src_r;
    assign bus.irq_vector   = irq_vector_r;
    assign bus.irq_priority = irq_priority_r;
    assign bus.psw_low_save = psw_low_save_r;
endmodule : imps_ctrl

// *** hdl/imps_core_end.sv ***
// core end: APB slave for software, passes ops and requests to the controller
module imps_core_end (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] src_req,
    input  wire logic [5:0]  op_sel,
    input  wire logic [15:0] stack_wdata,
    input  wire logic        vec_ack,
    input  wire logic        count_zero,
    input  wire logic [3:0]  count_zero_src,
    output logic             irq_valid,
    output logic [15:0]      irq_vector,
    output logic [4:0]       irq_priority,
    imps_if.core             bus
);
    import imps_pkg::*;

    logic        access;
    logic        known;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        irq_valid_r;
    logic [15:0] irq_vector_r;
    logic [4:0]  irq_priority_r;

    // access phase; the answer comes in its second cycle and a write lands on that edge
    assign access = psel & penable;
    assign known  = paddr == OFF_SEL || paddr == OFF_EOT || paddr == OFF_PEND_LO ||
                    paddr == OFF_PEND_HI || paddr == OFF_MASK_HI || paddr == OFF_MASK_LO;

    // software writes reserved and nmi mask bits as zero
    assign bus.reg_wr    = access & pready_r & pwrite & known;
    assign bus.reg_addr  = paddr;
    assign bus.reg_wdata = (paddr == OFF_MASK_HI) ? (pwdata[15:0] & {8'h00, MASK_HI_WMASK})
                         : (paddr == OFF_SEL) ? (pwdata[15:0] & SEL_WMASK)
                         : pwdata[15:0];
    assign bus.src_req           = src_req;
    assign bus.global_enable_op  = op_sel[0];
    assign bus.global_disable_op = op_sel[1];
    assign bus.push_flags_op     = op_sel[2];
    assign bus.push_all_op       = op_sel[3];
    assign bus.pop_flags_op      = op_sel[4];
    assign bus.pop_all_op        = op_sel[5];
    assign bus.stack_wdata       = stack_wdata;
    assign bus.vec_ack           = vec_ack;
    assign bus.count_zero        = count_zero;
    assign bus.count_zero_src    = count_zero_src;

    // one wait state: controller read data lands in the first access cycle, shown in the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= '0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= access & ~pready_r;
            pslverr_r <= access & ~pready_r & ~known;
            prdata_r  <= {16'h0000, bus.reg_rdata};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_valid_r    <= 1'b0;
            irq_vector_r   <= '0;
            irq_priority_r <= '0;
        end else begin
            irq_valid_r    <= bus.irq_valid;
            irq_vector_r   <= bus.irq_vector;
            irq_priority_r <= bus.irq_priority;
        end
    end

    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign irq_valid    = irq_valid_r;
    assign irq_vector   = irq_vector_r;
    assign irq_priority = irq_priority_r;
endmodule : imps_core_end

// *** sim/imps_props.sv ***
// checker: timing and vector properties on the signals between the two ends
module imps_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [15:0] src_req,
    input wire logic        global_enable_op,
    input wire logic        global_disable_op,
    input wire logic        push_flags_op,
    input wire logic        push_all_op,
    input wire logic        vec_ack,
    input wire logic        irq_valid,
    input wire logic        irq_is_mct,
    input wire logic [3:0]  irq_src,
    input wire logic [15:0] irq_vector,
    input wire logic [4:0]  irq_priority
);
    timeunit 1ns;
    timeprecision 1ps;

    logic ge_r;
    logic ge_d_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // global enable as last ordered, and one cycle later for the registered pick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ge_r   <= 1'b0;
            ge_d_r <= 1'b0;
        end else begin
            ge_r   <= global_enable_op ? 1'b1 : (global_disable_op ? 1'b0 : ge_r);
            ge_d_r <= ge_r;
        end
    end

    chk_nmi_vector: assert property (irq_valid && !irq_is_mct && irq_src == 4'hF
        |-> irq_vector == 16'h203E && irq_priority == 5'h1E) else $error("nmi vector wrong");
    chk_std_prio: assert property (irq_valid && !irq_is_mct && irq_src != 4'hF
        |-> irq_priority == {1'b0, irq_src}) else $error("standard priority wrong");
    chk_mct_vector: assert property (irq_valid && irq_is_mct
        |-> irq_vector == 16'h2040 + {11'h000, irq_src, 1'b0}
            && irq_priority == 5'h0F + {1'b0, irq_src}) else $error("transfer vector wrong");
    chk_std_shared: assert property (irq_valid && !irq_is_mct && irq_src == 4'h0
        |-> irq_vector == 16'h2000) else $error("shared vector wrong");
    chk_ack_drop: assert property (vec_ack && irq_valid |=> !irq_valid)
        else $error("request stayed after vector taken");
    chk_push_hold: assert property (push_flags_op || push_all_op
        |-> ##2 (!irq_valid || irq_src == 4'hF)) else $error("call right after push");
    chk_global_gate: assert property (!ge_r && !ge_d_r && irq_valid
        |-> irq_src == 4'hF && !irq_is_mct) else $error("maskable call while disabled");
    chk_nmi_taken: assert property ($rose(src_req[15]) && !irq_valid
        |-> ##[1:4] (irq_valid && irq_src == 4'hF)) else $error("nmi not presented");
endmodule : imps_props

// *** sim/imps_bench.sv ***
// testbench: both ends joined by the interface, driven over apb and the core side
module imps_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import imps_pkg::*;

    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, vec_ack = 0, count_zero = 0;
    logic [15:0] src_req = 16'h0, stack_wdata = 16'h0;
    logic [5:0]  op_sel = 6'h00;
    logic [3:0]  count_zero_src = 4'h0;
    logic        core_irq_valid;
    logic [15:0] core_irq_vector;
    logic [4:0]  core_irq_priority;
    int          error_cnt = 0, n_tests = 0;

    imps_if u_if ();
    imps_ctrl i_imps_ctrl (.pclk(pclk), .presetn(presetn), .bus(u_if.ctrl));
    imps_core_end i_imps_core_end (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_req(src_req), .op_sel(op_sel),
        .stack_wdata(stack_wdata), .vec_ack(vec_ack), .count_zero(count_zero),
        .count_zero_src(count_zero_src), .irq_valid(core_irq_valid),
        .irq_vector(core_irq_vector), .irq_priority(core_irq_priority),
        .bus(u_if.core));
    imps_props i_imps_props (.pclk(pclk), .presetn(presetn), .src_req(u_if.src_req),
        .global_enable_op(u_if.global_enable_op), .global_disable_op(u_if.global_disable_op),
        .push_flags_op(u_if.push_flags_op), .push_all_op(u_if.push_all_op),
        .vec_ack(u_if.vec_ack), .irq_valid(u_if.irq_valid), .irq_is_mct(u_if.irq_is_mct),
        .irq_src(u_if.irq_src), .irq_vector(u_if.irq_vector), .irq_priority(u_if.irq_priority));

    always #20 pclk = ~pclk;

    task automatic final_report();
        $display("errors=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, {16'h0000, d}, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, {16'h0000, exp});
    endtask : rd

    // one-cycle pulses on the core-side op lines and source lines
    // op bits from 0 up: enable, disable, push flags, push all, pop flags, pop all
    task automatic op(input logic [5:0] b);
        @(posedge pclk); op_sel <= b;
        @(posedge pclk); op_sel <= 6'h00;
    endtask : op

    task automatic pulse_src(input logic [15:0] b);
        @(posedge pclk); src_req <= b;
        @(posedge pclk); src_req <= 16'h0;
    endtask : pulse_src

    task automatic get_irq(input logic [3:0] s, input logic m, input logic [4:0] p,
                           input logic [15:0] v);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            #1 n++;
        end while (u_if.irq_valid !== 1'b1 && n < 20);
        chk({u_if.irq_valid, u_if.irq_is_mct, u_if.irq_src, u_if.irq_priority}, {1'b1, m, s, p});
        if (v != 16'h0) chk(u_if.irq_vector, v);
        // the core end shows a registered copy one cycle later
        @(posedge pclk);
        #1 chk({core_irq_valid, core_irq_priority}, {1'b1, p});
        if (v != 16'h0) chk(core_irq_vector, v);
    endtask : get_irq

    task automatic ack();
        @(posedge pclk); vec_ack <= 1'b1;
        @(posedge pclk); vec_ack <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : ack

    task automatic quiet();
        logic s;
        s = 1'b0;
        repeat (6) begin
            @(posedge pclk);
            #1 s = s | u_if.irq_valid;
        end
        chk(s, 0);
    endtask : quiet

    task automatic t_reset();
        logic [31:0] q;
        logic e;
        rd(OFF_SEL, 16'h0); rd(OFF_EOT, 16'h0); rd(OFF_PEND_LO, 16'h0);
        rd(OFF_PEND_HI, 16'h0); rd(OFF_MASK_HI, 16'h0); rd(OFF_MASK_LO, 16'h0);
        apb(1'b1, 8'h20, 32'hFF, q, e);
        chk(e, 1);
    endtask : t_reset

    task automatic t_mask_gate();
        op(6'h02);
        wr(OFF_MASK_LO, 16'h00);
        pulse_src(16'h0020);
        quiet();
        rd(OFF_PEND_LO, 16'h20);
        wr(OFF_MASK_LO, 16'h20);
        quiet();
        op(6'h01);
        get_irq(4'h5, 1'b0, 5'h05, 16'h200A);
        ack();
        rd(OFF_PEND_LO, 16'h00);
    endtask : t_mask_gate

    task automatic t_soft_pend();
        wr(OFF_MASK_HI, 16'h10);
        wr(OFF_PEND_HI, 16'h10);
        get_irq(4'hC, 1'b0, 5'h0C, 16'h2038);
        ack();
        rd(OFF_PEND_HI, 16'h00);
    endtask : t_soft_pend

    task automatic t_priority();
        wr(OFF_MASK_LO, 16'hFF);
        wr(OFF_PEND_LO, 16'h13);
        get_irq(4'h4, 1'b0, 5'h04, 16'h0);
        ack();
        get_irq(4'h1, 1'b0, 5'h01, 16'h0);
        ack();
        get_irq(4'h0, 1'b0, 5'h00, 16'h2000);
        ack();
        rd(OFF_PEND_LO, 16'h00);
    endtask : t_priority

    task automatic t_transfer();
        wr(OFF_SEL, 16'h0008);
        rd(OFF_SEL, 16'h0008);
        wr(OFF_PEND_LO, 16'h08);
        get_irq(4'h3, 1'b1, 5'h12, 16'h2046);
        ack();
        @(posedge pclk); count_zero <= 1'b1; count_zero_src <= 4'h3;
        @(posedge pclk); count_zero <= 1'b0;
        rd(OFF_SEL, 16'h0000);
        rd(OFF_EOT, 16'h0008);
        get_irq(4'h3, 1'b0, 5'h03, 16'h2006);
        ack();
        rd(OFF_EOT, 16'h0000);
        wr(OFF_SEL, 16'h0008);
        rd(OFF_SEL, 16'h0008);
    endtask : t_transfer

    task automatic t_nmi();
        wr(OFF_MASK_HI, 16'hFF);
        rd(OFF_MASK_HI, 16'h5F);
        wr(OFF_SEL, 16'hFFFF);
        rd(OFF_SEL, 16'h5FFF);
        wr(OFF_SEL, 16'h0000);
        wr(OFF_MASK_HI, 16'h00);
        op(6'h02);
        pulse_src(16'h8000);
        get_irq(4'hF, 1'b0, 5'h1E, 16'h203E);
        ack();
    endtask : t_nmi

    task automatic t_push();
        wr(OFF_MASK_LO, 16'h04);
        op(6'h01);
        chk(u_if.psw_low_save, 32'h0004);
        op(6'h04);
        rd(OFF_MASK_LO, 16'h00);
        wr(OFF_PEND_LO, 16'h04);
        quiet();
        @(posedge pclk);
        stack_wdata <= 16'h0004;
        op(6'h10);
        get_irq(4'h2, 1'b0, 5'h02, 16'h2004);
        ack();
        wr(OFF_MASK_HI, 16'h10);
        wr(OFF_PEND_HI, 16'h10);
        get_irq(4'hC, 1'b0, 5'h0C, 16'h2038);
        op(6'h08);
        @(posedge pclk);
        #1 chk(u_if.irq_valid, 0);
        get_irq(4'hC, 1'b0, 5'h0C, 16'h2038);
        ack();
        rd(OFF_MASK_HI, 16'h10);
        @(posedge pclk);
        stack_wdata <= 16'h1203;
        op(6'h20);
        rd(OFF_MASK_HI, 16'h12);
        rd(OFF_MASK_LO, 16'h03);
    endtask : t_push

    initial begin
        #(40ns * 5000);
        error_cnt++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_mask_gate();
        t_soft_pend();
        t_priority();
        t_transfer();
        t_nmi();
        t_push();
        final_report();
    end
endmodule : imps_bench
